// [hw/ssc_path_timer.sv]
// Path point timer: spaces path points by counter times servo tick
`timescale 1ns/1ps
module ssc_path_timer #(
    parameter int CNT_W = ssc_pkg::PATH_CNT_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_tick,
    input wire logic i_load,
    input wire logic [CNT_W-1:0] i_limit,
    output logic o_point
);
    logic [CNT_W-1:0] cnt_q;

    // Count ticks; a zero limit stalls the path point stream
    always_ff @(posedge i_clk) begin
        if (i_rst || (i_ce && i_load)) begin
            cnt_q <= '0;
            o_point <= 1'b0;
        end else if (i_ce) begin
            o_point <= 1'b0;
            if (i_tick && i_limit != '0) begin
                if (cnt_q + CNT_W'(1) >= i_limit) begin // [RL14]
                    cnt_q <= '0;
                    o_point <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + CNT_W'(1);
                end
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_point_spacing;
        o_point |-> cnt_q == '0 && $past(cnt_q) == i_limit - CNT_W'(1);
    endproperty
    a_point_spacing: assert property (p_point_spacing) // [RL14]
        else $error("Path point not at counter limit");
endmodule

// [hw/ssc_pkg.sv]
// Package: constants and types of the servo stop and I/O control block
package ssc_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_STOP_CTRL = 8'h00;
    localparam logic [7:0] OFF_STOP_POS = 8'h04;
    localparam logic [7:0] OFF_IO_CTRL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_ERR_LIMIT = 8'h18;
    localparam logic [7:0] OFF_PATH_CNT = 8'h1C;
    localparam logic [7:0] OFF_ACT_POS = 8'h20;
    // I/O control field positions
    localparam int IO_BRAKE_SEL_BIT = 0;
    localparam int IO_BRAKE_LVL_BIT = 1;
    localparam int IO_TIMEBASE_BIT = 6;
    localparam int IO_COUNT_LSB = 16;
    localparam int PATH_CNT_W = 15;
    // Status byte bit positions
    localparam int ST_SERVO_BIT = 0;
    localparam int ST_VEL_BIT = 1;
    localparam int ST_TRACK_BIT = 2;
    localparam int ST_POWER_BIT = 3;
    localparam int ST_POSERR_BIT = 4;
    localparam int ST_REV_BIT = 5;
    localparam int ST_FWD_BIT = 6;
    localparam int ST_BRAKE_BIT = 7;
    // Interrupt event bit positions
    localparam int IRQ_W = 3;
    localparam int EV_POSERR = 0;
    localparam int EV_POINT = 1;
    localparam int EV_STOP = 2;
    // Values after reset
    localparam logic [15:0] RST_ERR_LIMIT = 16'h3FFF;
    localparam logic [14:0] RST_PATH_CNT = 15'h0000;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    // Servo tick timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SERVO_TICK_NS = 51200;
    localparam int SERVO_TICK_CYC = SERVO_TICK_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;

    // Stop control byte layout
    typedef struct packed {
        logic [2:0] unused;
        logic stop_here;
        logic smooth;
        logic abrupt;
        logic motor_off;
        logic power_en;
    } ssc_stop_ctrl_type;

    // Commands towards the servo loop and profiler
    typedef struct packed {
        logic servo_en;
        logic pwm_zero;
        logic vel_mode;
        logic cmd_vel_zero;
        logic goal_vel_zero;
        logic pos_load;
        logic [31:0] goal_pos;
    } ssc_motion_type;

    typedef enum logic [3:0] {
        MD_OFF = 4'h1,
        MD_PROFILE = 4'h2,
        MD_VELOCITY = 4'h4,
        MD_TRACK = 4'h8
    } ssc_mode_type;
endpackage

// [hw/ssc_tick_gen.sv]
// Servo tick generator: one-cycle pulse every servo tick period
`timescale 1ns/1ps
module ssc_tick_gen #(
    parameter int TICK_CYC = ssc_pkg::SERVO_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    output logic o_tick
);
    logic [15:0] cnt_q;

    // Free-running divider, frozen by the clock enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 16'h0000;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            if (cnt_q == 16'(TICK_CYC - 1)) begin
                cnt_q <= 16'h0000;
                o_tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
                o_tick <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_tick_period;
        o_tick |-> cnt_q == 16'h0000;
    endproperty
    a_tick_period: assert property (p_tick_period) // [RL14]
        else $error("Tick pulse out of phase with divider");
endmodule

// [hw/ssc_top.sv]
// Servo stop-motor and I/O control command block with register port
// Notes on behaviour
// RL1 - Stop byte bit 0 enables the power stage, clear disables it.
// RL2 - Power enable changes how power-on and both limit bits report.
// RL3 - Motor-off disables servo, zeroes PWM, ignores other stop bits.
// RL4 - Abrupt stop zeroes command and goal velocity in velocity mode.
// RL5 - Abrupt stop holds the present position with no ramp.
// RL6 - Smooth stop zeroes goal velocity and enters velocity mode.
// RL7 - Stop-here commands the supplied position with no profiling.
// RL8 - A jump beyond the error limit raises the position error.
// RL9 - The host sets at most one of the four stopping-method bits.
// RL10 - The host sends a stop command before any other motion.
// RL11 - Brake select picks device status or manual level for brake.
// RL12 - Manual brake follows the level bit, else that bit is unused.
// RL13 - Time-base bit loads the path counter, range 0 to 7FFF.
// RL14 - Path points are spaced by counter times the servo tick.
// RL15 - Stopping position accompanies only the stop-here bit.
// RL16 - Unused I/O control bits are ignored by the device.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module ssc_top #(
    parameter int TICK_CYC = ssc_pkg::SERVO_TICK_CYC,
    parameter int LIM_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [31:0] i_actual_pos,
    input wire logic i_profile_start,
    input wire logic i_status_brake,
    input wire logic i_limit_rev,
    input wire logic i_limit_fwd,
    input wire logic i_supply_ok,
    output ssc_pkg::ssc_motion_type o_motion,
    output logic o_power_stage_enable,
    output logic o_brake,
    output logic o_path_point,
    output logic o_servo_tick,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    ssc_pkg::ssc_stop_ctrl_type stop_cmd;
    ssc_pkg::ssc_mode_type mode_q;
    logic [31:0] stop_pos_q;
    logic power_en_q;
    logic brake_sel_q;
    logic brake_lvl_q;
    logic [ssc_pkg::PATH_CNT_W-1:0] path_cnt_q;
    logic [LIM_W-1:0] err_limit_q;
    logic [ssc_pkg::IRQ_W-1:0] irq_stat_q;
    logic [ssc_pkg::IRQ_W-1:0] irq_mask_q;
    logic [ssc_pkg::IRQ_W-1:0] irq_ev;
    logic [2:0] pin_raw;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_q;
    logic [7:0] status_byte;
    logic stop_wr;
    logic io_wr;
    logic tb_load;
    logic jump_err;
    logic [32:0] pos_diff;
    logic [32:0] pos_abs;
    logic poserr_q;
    logic poserr_prev_q;

    // Register write decode, shared by every write path
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = i_ce && i_wr && (i_addr == off);
    endfunction

    assign stop_cmd = ssc_pkg::ssc_stop_ctrl_type'(i_wdata[7:0]);
    assign stop_wr = wr_hit(ssc_pkg::OFF_STOP_CTRL);
    assign io_wr = wr_hit(ssc_pkg::OFF_IO_CTRL);
    assign tb_load = io_wr && i_wdata[ssc_pkg::IO_TIMEBASE_BIT]; // [RL13]

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change accepted once 2 and 3 agree
    assign pin_raw = {i_supply_ok, i_limit_fwd, i_limit_rev};
    generate
        for (genvar g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    pin_s1_q[g] <= 1'b0;
                    pin_s2_q[g] <= 1'b0;
                    pin_s3_q[g] <= 1'b0;
                    pin_q[g] <= 1'b0;
                end else if (i_ce) begin
                    pin_s1_q[g] <= pin_raw[g];
                    pin_s2_q[g] <= pin_s1_q[g];
                    pin_s3_q[g] <= pin_s2_q[g];
                    if (pin_s2_q[g] == pin_s3_q[g]) begin
                        pin_q[g] <= pin_s3_q[g];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Stopping position and error limit storage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stop_pos_q <= 32'h00000000;
            err_limit_q <= LIM_W'(ssc_pkg::RST_ERR_LIMIT);
        end else begin
            if (wr_hit(ssc_pkg::OFF_STOP_POS)) begin
                stop_pos_q <= i_wdata; // [RL15]
            end
            if (wr_hit(ssc_pkg::OFF_ERR_LIMIT)) begin
                err_limit_q <= i_wdata[LIM_W-1:0];
            end
        end
    end

    // Power stage enable; off after reset until a stop command lands
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            power_en_q <= 1'b0; // [RL10]
        end else if (stop_wr) begin
            power_en_q <= stop_cmd.power_en; // [RL1]
        end
    end
    assign o_power_stage_enable = power_en_q;

    ////////////////////////////////////////////////////////////////////
    // Jump size check; 33 bits so a full-range difference cannot wrap
    assign pos_diff = {stop_pos_q[31], stop_pos_q}
        - {i_actual_pos[31], i_actual_pos};
    assign pos_abs = pos_diff[32] ? (33'h000000000 - pos_diff) : pos_diff;
    assign jump_err = pos_abs > {17'h00000, 16'(err_limit_q)}; // [RL8]

    // Servo mode; motor-off outranks abrupt, smooth, then stop-here
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_q <= ssc_pkg::MD_OFF;
        end else if (i_ce) begin
            if (stop_wr && stop_cmd.motor_off) begin
                mode_q <= ssc_pkg::MD_OFF; // [RL3]
            end else if (stop_wr && stop_cmd.abrupt) begin
                mode_q <= ssc_pkg::MD_VELOCITY; // [RL4]
            end else if (stop_wr && stop_cmd.smooth) begin
                mode_q <= ssc_pkg::MD_VELOCITY; // [RL6]
            end else if (stop_wr && stop_cmd.stop_here) begin
                mode_q <= ssc_pkg::MD_TRACK; // [RL7]
            end else if (i_profile_start && mode_q != ssc_pkg::MD_OFF) begin
                mode_q <= ssc_pkg::MD_PROFILE;
            end
        end
    end

    // Motion command outputs; zero and load strobes last one cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_motion.cmd_vel_zero <= 1'b0;
            o_motion.goal_vel_zero <= 1'b0;
            o_motion.pos_load <= 1'b0;
            o_motion.goal_pos <= 32'h00000000;
        end else if (i_ce) begin
            o_motion.cmd_vel_zero <= 1'b0;
            o_motion.goal_vel_zero <= 1'b0;
            o_motion.pos_load <= 1'b0;
            if (stop_wr && !stop_cmd.motor_off) begin
                if (stop_cmd.abrupt) begin
                    o_motion.cmd_vel_zero <= 1'b1; // [RL4]
                    o_motion.goal_vel_zero <= 1'b1; // [RL4]
                    o_motion.goal_pos <= i_actual_pos; // [RL5]
                    o_motion.pos_load <= 1'b1; // [RL5]
                end else if (stop_cmd.smooth) begin
                    o_motion.goal_vel_zero <= 1'b1; // [RL6]
                end else if (stop_cmd.stop_here) begin
                    o_motion.goal_pos <= stop_pos_q; // [RL7]
                    o_motion.pos_load <= 1'b1; // [RL7]
                end
            end
        end
    end

    // Mode decode to loop controls, one cycle after the mode register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_motion.servo_en <= 1'b0;
            o_motion.vel_mode <= 1'b0;
        end else if (i_ce) begin
            unique case (mode_q)
                ssc_pkg::MD_OFF: begin
                    o_motion.servo_en <= 1'b0;
                    o_motion.vel_mode <= 1'b0;
                end
                ssc_pkg::MD_VELOCITY: begin
                    o_motion.servo_en <= 1'b1;
                    o_motion.vel_mode <= 1'b1;
                end
                ssc_pkg::MD_PROFILE, ssc_pkg::MD_TRACK: begin
                    o_motion.servo_en <= 1'b1;
                    o_motion.vel_mode <= 1'b0;
                end
            endcase
        end
    end

    // PWM is forced to zero whenever the mode register holds MD_OFF
    always_comb begin
        o_motion.pwm_zero = (mode_q == ssc_pkg::MD_OFF); // [RL3]
    end

    ////////////////////////////////////////////////////////////////////
    // I/O control: only select, level, time-base and path count bits are looked at
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            brake_sel_q <= 1'b0;
            brake_lvl_q <= 1'b0;
            path_cnt_q <= ssc_pkg::RST_PATH_CNT;
        end else if (io_wr) begin
            brake_sel_q <= i_wdata[ssc_pkg::IO_BRAKE_SEL_BIT]; // [RL16]
            brake_lvl_q <= i_wdata[ssc_pkg::IO_BRAKE_LVL_BIT]; // [RL16]
            if (tb_load) begin
                path_cnt_q <= i_wdata[ssc_pkg::IO_COUNT_LSB +:
                    ssc_pkg::PATH_CNT_W]; // [RL13]
            end
        end
    end

    // Brake out: device status or the manual level
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_brake <= 1'b0;
        end else if (i_ce) begin
            o_brake <= brake_sel_q ? brake_lvl_q // [RL12]
                                   : i_status_brake; // [RL11]
        end
    end

    ssc_tick_gen #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .o_tick(o_servo_tick)
    );

    ssc_path_timer #(
        .CNT_W(ssc_pkg::PATH_CNT_W)
    ) u_path (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_tick(o_servo_tick),
        .i_load(tb_load),
        .i_limit(path_cnt_q),
        .o_point(o_path_point)
    );

    ////////////////////////////////////////////////////////////////////
    // Status byte; limits and power read zero while the stage is off
    always_comb begin
        status_byte = 8'h00;
        status_byte[ssc_pkg::ST_SERVO_BIT] = o_motion.servo_en;
        status_byte[ssc_pkg::ST_VEL_BIT] = o_motion.vel_mode;
        status_byte[ssc_pkg::ST_TRACK_BIT] = (mode_q == ssc_pkg::MD_TRACK);
        status_byte[ssc_pkg::ST_POWER_BIT] = power_en_q & pin_q[2]; // [RL2]
        status_byte[ssc_pkg::ST_POSERR_BIT] = poserr_q;
        status_byte[ssc_pkg::ST_REV_BIT] = power_en_q & pin_q[0]; // [RL2]
        status_byte[ssc_pkg::ST_FWD_BIT] = power_en_q & pin_q[1]; // [RL2]
        status_byte[ssc_pkg::ST_BRAKE_BIT] = o_brake;
    end

    // Sticky position error in the status byte; cleared by motor-off
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            poserr_q <= 1'b0;
        end else if (i_ce) begin
            if (stop_wr && stop_cmd.stop_here && !stop_cmd.motor_off
                && !stop_cmd.abrupt && !stop_cmd.smooth && jump_err) begin
                poserr_q <= 1'b1; // [RL8]
            end else if (stop_wr && stop_cmd.motor_off) begin
                poserr_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Previous error flag, so the event fires on its rise only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            poserr_prev_q <= 1'b0;
        end else if (i_ce) begin
            poserr_prev_q <= poserr_q;
        end
    end

    // Interrupt events; a set in the clearing cycle wins
    assign irq_ev[ssc_pkg::EV_POSERR] = poserr_q & ~poserr_prev_q;
    assign irq_ev[ssc_pkg::EV_POINT] = o_path_point;
    assign irq_ev[ssc_pkg::EV_STOP] = stop_wr;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat_q <= '0;
            irq_mask_q <= ssc_pkg::RST_IRQ_MASK;
        end else if (i_ce) begin
            if (wr_hit(ssc_pkg::OFF_IRQ_MASK)) begin
                irq_mask_q <= i_wdata[ssc_pkg::IRQ_W-1:0];
            end
            if (wr_hit(ssc_pkg::OFF_IRQ_STAT)) begin
                irq_stat_q <= (irq_stat_q & ~i_wdata[ssc_pkg::IRQ_W-1:0])
                    | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
        end
    end
    assign o_irq = |(irq_stat_q & irq_mask_q);

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_ce) begin
            o_rdata <= 32'h00000000;
            if (i_rd) begin
                case (i_addr)
                    ssc_pkg::OFF_STOP_POS: o_rdata <= stop_pos_q;
                    ssc_pkg::OFF_IO_CTRL: o_rdata <= {1'b0, path_cnt_q,
                        14'h0000, brake_lvl_q, brake_sel_q};
                    ssc_pkg::OFF_STATUS: o_rdata <= {24'h000000,
                        status_byte};
                    ssc_pkg::OFF_IRQ_STAT: o_rdata <= 32'(irq_stat_q);
                    ssc_pkg::OFF_IRQ_MASK: o_rdata <= 32'(irq_mask_q);
                    ssc_pkg::OFF_ERR_LIMIT: o_rdata <= 32'(err_limit_q);
                    ssc_pkg::OFF_PATH_CNT: o_rdata <= 32'(path_cnt_q);
                    ssc_pkg::OFF_ACT_POS: o_rdata <= i_actual_pos;
                    default: o_rdata <= {31'h00000000, power_en_q};
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_power_follow;
        stop_wr |=> o_power_stage_enable == $past(i_wdata[0]);
    endproperty
    a_power_follow: assert property (p_power_follow) // [RL1]
        else $error("Power enable does not follow stop byte");

    property p_status_gate;
        !power_en_q |-> status_byte[6:5] == 2'b00 && !status_byte[3];
    endproperty
    a_status_gate: assert property (p_status_gate) // [RL2]
        else $error("Limit or power bit set with stage disabled");

    property p_motor_off;
        stop_wr && stop_cmd.motor_off |=> o_motion.pwm_zero
            && !o_motion.pos_load && !o_motion.goal_vel_zero
            ##1 !o_motion.servo_en;
    endproperty
    a_motor_off: assert property (p_motor_off) // [RL3]
        else $error("Motor-off did not stop the servo");

    property p_abrupt;
        stop_wr && !stop_cmd.motor_off && stop_cmd.abrupt |=>
            o_motion.cmd_vel_zero && o_motion.goal_vel_zero
            ##1 o_motion.vel_mode && o_motion.servo_en;
    endproperty
    a_abrupt: assert property (p_abrupt) // [RL4]
        else $error("Abrupt stop did not zero velocities");

    property p_hold;
        stop_wr && !stop_cmd.motor_off && stop_cmd.abrupt |=>
            o_motion.goal_pos == $past(i_actual_pos) && o_motion.pos_load;
    endproperty
    a_hold: assert property (p_hold) // [RL5]
        else $error("Abrupt stop did not hold present position");

    property p_smooth;
        stop_wr && stop_cmd[2:1] == 2'b00 && stop_cmd.smooth |=>
            o_motion.goal_vel_zero && !o_motion.cmd_vel_zero
            ##1 o_motion.vel_mode;
    endproperty
    a_smooth: assert property (p_smooth) // [RL6]
        else $error("Smooth stop did not enter velocity mode");

    property p_track;
        stop_wr && stop_cmd[3:1] == 3'b000 && stop_cmd.stop_here |=>
            o_motion.pos_load && o_motion.goal_pos == $past(stop_pos_q);
    endproperty
    a_track: assert property (p_track) // [RL7]
        else $error("Stop-here did not load the stopping position");

    property p_jump_err;
        stop_wr && stop_cmd[3:1] == 3'b000 && stop_cmd.stop_here
            && jump_err ##1 i_ce |=> irq_stat_q[ssc_pkg::EV_POSERR];
    endproperty
    a_jump_err: assert property (p_jump_err) // [RL8]
        else $error("Oversized jump raised no position error");

    property p_brake;
        i_ce |=> o_brake == ($past(brake_sel_q) ? $past(brake_lvl_q)
            : $past(i_status_brake));
    endproperty
    a_brake: assert property (p_brake) // [RL11]
        else $error("Brake output from wrong source");

    property p_timebase;
        tb_load |=> path_cnt_q == $past(i_wdata[30:16]);
    endproperty
    a_timebase: assert property (p_timebase) // [RL13]
        else $error("Path counter not loaded by time-base bit");

    c_abrupt: cover property (stop_wr && stop_cmd == 8'h05);
    c_track_err: cover property (stop_wr && stop_cmd == 8'h11 && jump_err);
    c_point: cover property (o_path_point && path_cnt_q == 15'h0002);
endmodule

// [testbench/servo_stop_and_io_control_test.sv]
// Self-checking bench of the servo stop and I/O control block
`timescale 1ns/1ps
module servo_stop_and_io_control_test;
    logic i_clk, i_rst, i_ce, i_wr, i_rd, mv, ps;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, pos;
    logic sok, lrev, lfwd, sbrk, pse, brk, ppt, tck, irq;
    ssc_pkg::ssc_motion_type mot;
    int err_total = 0;
    int num_checks = 0;
    int n;

    // Short tick keeps path point spacing cheap to measure
    ssc_top #(.TICK_CYC(8)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_actual_pos(pos),
        .i_profile_start(ps), .i_status_brake(sbrk), .i_limit_rev(lrev),
        .i_limit_fwd(lfwd), .i_supply_ok(sok), .o_motion(mot),
        .o_power_stage_enable(pse), .o_brake(brk), .o_path_point(ppt),
        .o_servo_tick(tck), .o_irq(irq));
    ssc_plant_model u_plant (.i_clk(i_clk), .i_move(mv), .o_pos(pos),
        .o_supply_ok(sok), .o_limit_rev(lrev), .o_limit_fwd(lfwd),
        .o_status_brake(sbrk));

    // 50 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & m, e);
    endtask
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask
    task automatic t_reset;
        chk(32'({pse, mot.pwm_zero, irq, brk}), 32'h4);
        rd(ssc_pkg::OFF_ERR_LIMIT, 32'hFFFF, 32'h3FFF);
        rd(ssc_pkg::OFF_IRQ_MASK, 32'h7, 32'h0);
        rd(8'hFC, 32'hFFFF_FFFF, 32'h0);
    endtask
    task automatic t_abrupt;
        wr(ssc_pkg::OFF_STOP_CTRL, 32'h05);
        chk(32'({pse, mot.cmd_vel_zero, mot.goal_vel_zero, mot.pos_load,
            mot.pwm_zero}), 32'h1E);
        chk(mot.goal_pos, pos);
        step();
        chk(32'({mot.servo_en, mot.vel_mode, mot.cmd_vel_zero}), 32'h6);
        rd(ssc_pkg::OFF_STATUS, 32'h68, 32'h28);
        wr(ssc_pkg::OFF_STOP_CTRL, 32'h04);
        chk(32'(pse), 32'h0);
        rd(ssc_pkg::OFF_STATUS, 32'h68, 32'h0);
    endtask
    task automatic t_off_smooth;
        wr(ssc_pkg::OFF_STOP_CTRL, 32'h0F);
        chk(32'({pse, mot.pwm_zero, mot.cmd_vel_zero, mot.goal_vel_zero,
            mot.pos_load}), 32'h18);
        step();
        chk(32'({mot.servo_en, mot.vel_mode}), 32'h0);
        wr(ssc_pkg::OFF_STOP_CTRL, 32'h09);
        chk(32'({mot.cmd_vel_zero, mot.goal_vel_zero}), 32'h1);
        step();
        chk(32'(mot.vel_mode), 32'h1);
    endtask
    // Near jump is quiet; far jump flags error, masked then unmasked
    task automatic t_here;
        wr(ssc_pkg::OFF_STOP_POS, pos + 32'h5);
        wr(ssc_pkg::OFF_STOP_CTRL, 32'h11);
        chk(mot.goal_pos, pos + 32'h5);
        chk(32'(mot.pos_load), 32'h1);
        rd(ssc_pkg::OFF_STATUS, 32'h10, 32'h0);
        wr(ssc_pkg::OFF_STOP_POS, pos + 32'h5000);
        wr(ssc_pkg::OFF_STOP_CTRL, 32'h11);
        rd(ssc_pkg::OFF_STATUS, 32'h10, 32'h10);
        chk(32'(irq), 32'h0);
        rd(ssc_pkg::OFF_IRQ_STAT, 32'h1, 32'h1);
        wr(ssc_pkg::OFF_IRQ_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(ssc_pkg::OFF_IRQ_STAT, 32'h1);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_brake;
        wr(ssc_pkg::OFF_IO_CTRL, 32'h01);
        step();
        chk(32'(brk), 32'h0);
        wr(ssc_pkg::OFF_IO_CTRL, 32'hBF);
        step();
        chk(32'(brk), 32'h1);
        wr(ssc_pkg::OFF_IO_CTRL, 32'h02);
        mv <= 1'b1;
        step();
        mv <= 1'b0;
        repeat (3) step();
        chk(32'(brk), 32'(sbrk));
    endtask
    // Time to the next path point, or servo tick when t is set, in clock cycles
    task automatic gap(input bit t, output int c);
        c = 0;
        do begin
            step();
            c++;
        end while ((t ? tck : ppt) !== 1'b1 && c < 300);
    endtask
    task automatic t_path;
        wr(ssc_pkg::OFF_IO_CTRL, 32'h7FFF_0040);
        rd(ssc_pkg::OFF_PATH_CNT, 32'h7FFF, 32'h7FFF);
        wr(ssc_pkg::OFF_IO_CTRL, 32'h0003_0040);
        gap(1'b0, n);
        gap(1'b0, n);
        chk(32'(n), 32'd24);
        gap(1'b1, n);
        gap(1'b1, n);
        chk(32'(n), 32'd8);
    endtask

    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        mv = 1'b0;
        ps = 1'b0;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        step();
        t_reset();
        t_abrupt();
        t_off_smooth();
        t_here();
        t_brake();
        t_path();
        final_report();
    end
    // Watchdog well beyond the some 150 cycles the tests need
    initial begin
        #1000000;
        err_total++;
        final_report();
    end
endmodule

// [testbench/ssc_plant_model.sv]
// Plant stand-in: motor position, limit pins, supply and brake status
`timescale 1ns/1ps
module ssc_plant_model (
    input wire logic i_clk,
    input wire logic i_move,
    output logic [31:0] o_pos,
    output logic o_supply_ok,
    output logic o_limit_rev,
    output logic o_limit_fwd,
    output logic o_status_brake
);
    // Position steps only on request, so the bench always knows it
    initial o_pos = 32'h0000_1000;
    always @(posedge i_clk) begin
        if (i_move) begin
            o_pos <= o_pos + 32'h1;
        end
    end
    // Limits differ so a swapped pair shows up in the status byte
    assign o_supply_ok = 1'b1;
    assign o_limit_rev = 1'b1;
    assign o_limit_fwd = 1'b0;
    assign o_status_brake = o_pos[0];
endmodule
